// [logic/tpu_clk_clear_pkg.sv]
package tpu_clk_clear_pkg;

    // ------------------------------------------------------------
    // Widths and channel count
    // ------------------------------------------------------------
    localparam int unsigned NUM_CH    = 3;
    localparam int unsigned CNT_W     = 16;
    localparam int unsigned DIV_W     = 10;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL0  = 8'h00;
    localparam logic [7:0] OFS_CTRL1  = 8'h04;
    localparam logic [7:0] OFS_CTRL2  = 8'h08;
    localparam logic [7:0] OFS_CNT0   = 8'h0c;
    localparam logic [7:0] OFS_CNT1   = 8'h10;
    localparam logic [7:0] OFS_CNT2   = 8'h14;
    localparam logic [7:0] OFS_SYNC   = 8'h18;
    localparam logic [7:0] OFS_MODE   = 8'h1c;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int unsigned CTRL_CLR_TOP  = 7;   // Reserved on channels 1 and 2
    localparam int unsigned MODE_BUF_C    = 0;   // Channel 0 general_reg_c is a buffer
    localparam int unsigned MODE_BUF_D    = 1;   // Channel 0 general_reg_d is a buffer
    localparam int unsigned MODE_PHASE1   = 2;   // Channel 1 phase counting
    localparam int unsigned MODE_PHASE2   = 3;   // Channel 2 phase counting
    localparam int unsigned MODE_OVF_DIS  = 4;   // Variant without overflow chaining
    localparam int unsigned MODE_W        = 5;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0]        CTRL_RESET = 8'h00;
    localparam logic [2:0]        SYNC_RESET = 3'h0;
    localparam logic [MODE_W-1:0] MODE_RESET = 5'h00;

    // ------------------------------------------------------------
    // Clear field codes
    // ------------------------------------------------------------
    localparam logic [2:0] CLR_NONE  = 3'h0;
    localparam logic [2:0] CLR_A     = 3'h1;
    localparam logic [2:0] CLR_B     = 3'h2;
    localparam logic [2:0] CLR_SYNC  = 3'h3;
    localparam logic [2:0] CLR_NONE2 = 3'h4;
    localparam logic [2:0] CLR_C     = 3'h5;
    localparam logic [2:0] CLR_D     = 3'h6;
    localparam logic [2:0] CLR_SYNC2 = 3'h7;

    // ------------------------------------------------------------
    // Divider tap masks: a tap of phi/N rises when the low bits are all ones
    // ------------------------------------------------------------
    localparam logic [DIV_W-1:0] TAP_1    = 10'h000;
    localparam logic [DIV_W-1:0] TAP_4    = 10'h003;
    localparam logic [DIV_W-1:0] TAP_16   = 10'h00f;
    localparam logic [DIV_W-1:0] TAP_64   = 10'h03f;
    localparam logic [DIV_W-1:0] TAP_256  = 10'h0ff;
    localparam logic [DIV_W-1:0] TAP_1024 = 10'h3ff;

    // Per-channel control word carried as one unit
    typedef struct packed {
        logic [2:0] clearSrc;
        logic [1:0] edgeSel;
        logic [2:0] prescaleSel;
    } chan_ctrl_t;

endpackage

// [logic/tpu_clk_clear.sv]
// The AHB-Lite register port and the register offsets were left to the implementer.
`timescale 1ns/100ps

module tpu_clk_clear #(
    parameter int unsigned CNT_W = tpu_clk_clear_pkg::CNT_W
) (
    input  wire logic                    clk,
    input  wire logic                    rst,
    // AHB-Lite slave
    input  wire logic                    hsel,
    input  wire logic [31:0]             haddr,
    input  wire logic [1:0]              htrans,
    input  wire logic                    hwrite,
    input  wire logic [2:0]              hsize,
    input  wire logic [31:0]             hwdata,
    input  wire logic                    hready,
    output logic      [31:0]             hrdata,
    output logic                         hreadyout,
    output logic                         hresp,
    // External clock pins A..D, asynchronous
    input  wire logic [3:0]              extClkPin,
    // Compare match / capture pulses from same-clock logic
    input  wire logic [2:0]              matchA,
    input  wire logic [2:0]              matchB,
    input  wire logic                    matchC,
    input  wire logic                    matchD,
    // Phase counting count pulses, bit 0 channel 1, bit 1 channel 2
    input  wire logic [1:0]              phaseTick,
    // Counter values
    output logic [2:0][CNT_W-1:0]        channelCounter
);

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------

    // Tap of the free divider rises when the masked bits are all ones
    function automatic logic tap_rise(input logic [9:0] div, input logic [9:0] mask);
        tap_rise = ((div & mask) == mask);
    endfunction

    // Tap falls half a period later
    function automatic logic tap_fall(input logic [9:0] div, input logic [9:0] mask);
        tap_fall = ((div & mask) == (mask >> 1));
    endfunction

    // Apply the edge field to a rising and falling event pair
    function automatic logic pick_edge(input logic [1:0] edgeSel, input logic rise, input logic fall);
        if (edgeSel[1]) begin
            pick_edge = rise | fall;
        end else if (edgeSel[0]) begin
            pick_edge = fall;
        end else begin
            pick_edge = rise;
        end
    endfunction

    // Register decode of one byte offset
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
        hit = (addr == ofs);
    endfunction

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    tpu_clk_clear_pkg::chan_ctrl_t [2:0]          ctrl_q;
    logic [2:0]                                   sync_q;
    logic [tpu_clk_clear_pkg::MODE_W-1:0]         mode_q;
    logic [2:0][CNT_W-1:0]                        cnt_q;
    logic [2:0][CNT_W-1:0]                        cnt_d;
    logic [tpu_clk_clear_pkg::DIV_W-1:0]          div_q;
    logic [3:0]                                   pinMeta_q;
    logic [3:0]                                   pinSync_q;
    logic [3:0]                                   pinPrev_q;
    logic [3:0]                                   pinRise;
    logic [3:0]                                   pinFall;
    logic                                         ovf2_q;
    logic [2:0]                                   countEn;
    logic [2:0]                                   ownClear;
    logic [2:0]                                   syncSel;
    logic [2:0]                                   doClear;
    logic                                         dataWrite_q;
    logic [7:0]                                   dataAddr_q;
    logic                                         addrValid;
    logic [31:0]                                  readMux;

    // ------------------------------------------------------------
    // AHB-Lite slave
    // ------------------------------------------------------------

    // Address phase taken when selected with a non-idle transfer
    assign addrValid = hsel & htrans[1] & hready;

    // Data-phase bookkeeping
    always_ff @(posedge clk) begin
        if (rst) begin
            dataWrite_q <= 1'b0;
            dataAddr_q  <= 8'h00;
        end else if (hready) begin
            dataWrite_q <= addrValid & hwrite;
            dataAddr_q  <= {haddr[7:2], 2'b00};
        end
    end

    // Always ready, always OKAY; same value in and out of reset
    always_ff @(posedge clk) begin
        hreadyout <= 1'b1;
        hresp     <= 1'b0;
    end

    // Read mux by address-phase offset; unmapped reads zero
    always_comb begin
        readMux = 32'h0000_0000;
        if (hit({haddr[7:2], 2'b00}, tpu_clk_clear_pkg::OFS_CTRL0)) begin
            readMux[7:0] = ctrl_q[0];
        end else if (hit({haddr[7:2], 2'b00}, tpu_clk_clear_pkg::OFS_CTRL1)) begin
            readMux[7:0] = ctrl_q[1];
        end else if (hit({haddr[7:2], 2'b00}, tpu_clk_clear_pkg::OFS_CTRL2)) begin
            readMux[7:0] = ctrl_q[2];
        end else if (hit({haddr[7:2], 2'b00}, tpu_clk_clear_pkg::OFS_CNT0)) begin
            readMux[CNT_W-1:0] = cnt_q[0];
        end else if (hit({haddr[7:2], 2'b00}, tpu_clk_clear_pkg::OFS_CNT1)) begin
            readMux[CNT_W-1:0] = cnt_q[1];
        end else if (hit({haddr[7:2], 2'b00}, tpu_clk_clear_pkg::OFS_CNT2)) begin
            readMux[CNT_W-1:0] = cnt_q[2];
        end else if (hit({haddr[7:2], 2'b00}, tpu_clk_clear_pkg::OFS_SYNC)) begin
            readMux[2:0] = sync_q;
        end else if (hit({haddr[7:2], 2'b00}, tpu_clk_clear_pkg::OFS_MODE)) begin
            readMux[tpu_clk_clear_pkg::MODE_W-1:0] = mode_q;
        end
    end

    // Read data registered at the address phase, stands in the data phase
    always_ff @(posedge clk) begin
        if (rst) begin
            hrdata <= 32'h0000_0000;
        end else if (addrValid & ~hwrite) begin
            hrdata <= readMux;
        end
    end

    // ------------------------------------------------------------
    // Control, sync and mode registers
    // ------------------------------------------------------------

    // Software writes in the data phase
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_q <= {3{tpu_clk_clear_pkg::CTRL_RESET}};
            sync_q <= tpu_clk_clear_pkg::SYNC_RESET;
            mode_q <= tpu_clk_clear_pkg::MODE_RESET;
        end else if (dataWrite_q) begin
            if (hit(dataAddr_q, tpu_clk_clear_pkg::OFS_CTRL0)) begin
                ctrl_q[0] <= hwdata[7:0];
            end
            if (hit(dataAddr_q, tpu_clk_clear_pkg::OFS_CTRL1)) begin
                ctrl_q[1] <= {1'b0, hwdata[tpu_clk_clear_pkg::CTRL_CLR_TOP-1:0]};
            end
            if (hit(dataAddr_q, tpu_clk_clear_pkg::OFS_CTRL2)) begin
                ctrl_q[2] <= {1'b0, hwdata[tpu_clk_clear_pkg::CTRL_CLR_TOP-1:0]};
            end
            if (hit(dataAddr_q, tpu_clk_clear_pkg::OFS_SYNC)) begin
                sync_q <= hwdata[2:0];
            end
            if (hit(dataAddr_q, tpu_clk_clear_pkg::OFS_MODE)) begin
                mode_q <= hwdata[tpu_clk_clear_pkg::MODE_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Count clock sources
    // ------------------------------------------------------------

    // Free-running prescaler divider
    always_ff @(posedge clk) begin
        if (rst) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 1'b1;
        end
    end

    // Two-flop synchroniser on the external pins, then history flop
    always_ff @(posedge clk) begin
        if (rst) begin
            pinMeta_q <= 4'h0;
            pinSync_q <= 4'h0;
            pinPrev_q <= 4'h0;
        end else begin
            pinMeta_q <= extClkPin;
            pinSync_q <= pinMeta_q;
            pinPrev_q <= pinSync_q;
        end
    end

    assign pinRise = pinSync_q & ~pinPrev_q;
    assign pinFall = ~pinSync_q & pinPrev_q;

    // Per-channel count enable from prescaler code and edge field
    always_comb begin
        countEn = 3'b000;
        for (int ch = 0; ch < 3; ch++) begin
            case (ctrl_q[ch].prescaleSel)
                3'h0: countEn[ch] = tap_rise(div_q, tpu_clk_clear_pkg::TAP_1);
                3'h1: countEn[ch] = tap_rise(div_q, tpu_clk_clear_pkg::TAP_4);
                3'h2: countEn[ch] = pick_edge(ctrl_q[ch].edgeSel, tap_rise(div_q, tpu_clk_clear_pkg::TAP_16),
                                              tap_fall(div_q, tpu_clk_clear_pkg::TAP_16));
                3'h3: countEn[ch] = pick_edge(ctrl_q[ch].edgeSel, tap_rise(div_q, tpu_clk_clear_pkg::TAP_64),
                                              tap_fall(div_q, tpu_clk_clear_pkg::TAP_64));
                3'h4: countEn[ch] = pick_edge(ctrl_q[ch].edgeSel, pinRise[0], pinFall[0]);
                3'h5: countEn[ch] = pick_edge(ctrl_q[ch].edgeSel, pinRise[1], pinFall[1]);
                3'h6: begin
                    if (ch == 1) begin
                        countEn[ch] = pick_edge(ctrl_q[ch].edgeSel, tap_rise(div_q, tpu_clk_clear_pkg::TAP_256),
                                                tap_fall(div_q, tpu_clk_clear_pkg::TAP_256));
                    end else begin
                        countEn[ch] = pick_edge(ctrl_q[ch].edgeSel, pinRise[2], pinFall[2]);
                    end
                end
                3'h7: begin
                    if (ch == 0) begin
                        countEn[ch] = pick_edge(ctrl_q[ch].edgeSel, pinRise[3], pinFall[3]);
                    end else if (ch == 1) begin
                        countEn[ch] = ovf2_q & ~mode_q[tpu_clk_clear_pkg::MODE_OVF_DIS];
                    end else begin
                        countEn[ch] = pick_edge(ctrl_q[ch].edgeSel, tap_rise(div_q, tpu_clk_clear_pkg::TAP_1024),
                                                tap_fall(div_q, tpu_clk_clear_pkg::TAP_1024));
                    end
                end
                default: countEn[ch] = 1'b0;
            endcase
        end
        if (mode_q[tpu_clk_clear_pkg::MODE_PHASE1]) begin
            countEn[1] = phaseTick[0];
        end
        if (mode_q[tpu_clk_clear_pkg::MODE_PHASE2]) begin
            countEn[2] = phaseTick[1];
        end
    end

    // ------------------------------------------------------------
    // Clearing sources
    // ------------------------------------------------------------

    // Own clear events and synchronous-clear selection per channel
    always_comb begin
        ownClear = 3'b000;
        syncSel  = 3'b000;
        for (int ch = 0; ch < 3; ch++) begin
            case (ctrl_q[ch].clearSrc)
                tpu_clk_clear_pkg::CLR_NONE:  ownClear[ch] = 1'b0;
                tpu_clk_clear_pkg::CLR_A:     ownClear[ch] = matchA[ch];
                tpu_clk_clear_pkg::CLR_B:     ownClear[ch] = matchB[ch];
                tpu_clk_clear_pkg::CLR_SYNC:  syncSel[ch]  = 1'b1;
                tpu_clk_clear_pkg::CLR_NONE2: ownClear[ch] = 1'b0;
                tpu_clk_clear_pkg::CLR_C:     ownClear[ch] = (ch == 0) & matchC &
                                                             ~mode_q[tpu_clk_clear_pkg::MODE_BUF_C];
                tpu_clk_clear_pkg::CLR_D:     ownClear[ch] = (ch == 0) & matchD &
                                                             ~mode_q[tpu_clk_clear_pkg::MODE_BUF_D];
                tpu_clk_clear_pkg::CLR_SYNC2: syncSel[ch]  = (ch == 0);
                default:                      ownClear[ch] = 1'b0;
            endcase
        end
    end

    // Sync clear follows any other synchronous channel that clears itself
    always_comb begin
        doClear = ownClear;
        for (int ch = 0; ch < 3; ch++) begin
            for (int o = 0; o < 3; o++) begin
                if (o != ch && syncSel[ch] && sync_q[ch] && sync_q[o] && ownClear[o]) begin
                    doClear[ch] = 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Counters
    // ------------------------------------------------------------

    // Next counter value: bus write, then clear, then count
    always_comb begin
        cnt_d = cnt_q;
        for (int ch = 0; ch < 3; ch++) begin
            if (doClear[ch]) begin
                cnt_d[ch] = '0;
            end else if (countEn[ch]) begin
                cnt_d[ch] = cnt_q[ch] + 1'b1;
            end
        end
        if (dataWrite_q && hit(dataAddr_q, tpu_clk_clear_pkg::OFS_CNT0)) begin
            cnt_d[0] = hwdata[CNT_W-1:0];
        end
        if (dataWrite_q && hit(dataAddr_q, tpu_clk_clear_pkg::OFS_CNT1)) begin
            cnt_d[1] = hwdata[CNT_W-1:0];
        end
        if (dataWrite_q && hit(dataAddr_q, tpu_clk_clear_pkg::OFS_CNT2)) begin
            cnt_d[2] = hwdata[CNT_W-1:0];
        end
    end

    // Counter registers
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // Channel 2 overflow pulse, set on the same edge as the wrap
    always_ff @(posedge clk) begin
        if (rst) begin
            ovf2_q <= 1'b0;
        end else begin
            ovf2_q <= countEn[2] & ~doClear[2] & (&cnt_q[2]);
        end
    end

    // Counter outputs straight from flops
    always_ff @(posedge clk) begin
        if (rst) begin
            channelCounter <= '0;
        end else begin
            channelCounter <= cnt_d;
        end
    end

endmodule // tpu_clk_clear

// [dv/tpu_clk_clear_checker.sv]
`timescale 1ns/100ps

module tpu_clk_clear_checker #(
    parameter int unsigned CNT_W = 16
) (
    input wire logic                  clk,
    input wire logic                  rst,
    input wire logic                  hsel,
    input wire logic [31:0]           haddr,
    input wire logic [1:0]            htrans,
    input wire logic                  hwrite,
    input wire logic [31:0]           hwdata,
    input wire logic                  hready,
    input wire logic [31:0]           hrdata,
    input wire logic [2:0]            matchA,
    input wire logic [2:0]            matchB,
    input wire logic                  matchC,
    input wire logic                  matchD,
    input wire logic [2:0][CNT_W-1:0] channelCounter
);
    // ------------------------------------------------------------
    // Bus phase tracking and channel 0 settings shadow
    // ------------------------------------------------------------
    logic       wrPh_q, rdPh_q;
    logic [7:0] adr_q, ctrl0_q;
    logic [4:0] mode_q;

    // Follows data phases and mirrors control writes
    always_ff @(posedge clk) begin
        if (rst) begin
            wrPh_q  <= 1'b0;
            rdPh_q  <= 1'b0;
            adr_q   <= 8'h00;
            ctrl0_q <= tpu_clk_clear_pkg::CTRL_RESET;
            mode_q  <= tpu_clk_clear_pkg::MODE_RESET;
        end else begin
            wrPh_q <= hsel & htrans[1] & hready & hwrite;
            rdPh_q <= hsel & htrans[1] & hready & ~hwrite;
            if (hsel & htrans[1] & hready) adr_q <= haddr[7:0];
            if (wrPh_q && adr_q == 8'h00) ctrl0_q <= hwdata[7:0];
            if (wrPh_q && adr_q == 8'h1c) mode_q <= hwdata[4:0];
        end
    end

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_zero0;
        channelCounter[0] == '0;
    endsequence
    sequence s_step0;
        channelCounter[0] == CNT_W'($past(channelCounter[0]) + 1'b1);
    endsequence

    property p_clrA; !wrPh_q && ctrl0_q[7:5] == 3'h1 && matchA[0] |=> s_zero0; endproperty
    property p_clrB; !wrPh_q && ctrl0_q[7:5] == 3'h2 && matchB[0] |=> s_zero0; endproperty
    property p_clrC; !wrPh_q && ctrl0_q[7:5] == 3'h5 && matchC && !mode_q[0] |=> s_zero0; endproperty
    property p_clrD; !wrPh_q && ctrl0_q[7:5] == 3'h6 && matchD && !mode_q[1] |=> s_zero0; endproperty
    property p_buf; !wrPh_q && ctrl0_q == 8'ha0 && matchC && mode_q[0] |=> s_step0; endproperty
    property p_none; !wrPh_q && ctrl0_q == 8'h00 |=> s_step0; endproperty
    property p_rsvd; rdPh_q && adr_q inside {8'h04, 8'h08} |-> hrdata[7] == 1'b0; endproperty
    property p_rst; $fell(rst) |-> channelCounter == '0; endproperty

    a_clrA: assert property (p_clrA) else $error("no clear on A");
    a_clrB: assert property (p_clrB) else $error("no clear on B");
    a_clrC: assert property (p_clrC) else $error("no clear on C");
    a_clrD: assert property (p_clrD) else $error("no clear on D");
    a_buf: assert property (p_buf) else $error("buffer C cleared");
    a_none: assert property (p_none) else $error("bad count");
    a_rsvd: assert property (p_rsvd) else $error("top bit set");
    a_rst: assert property (p_rst) else $error("counter not zero");
endmodule  // tpu_clk_clear_checker

bind tpu_clk_clear tpu_clk_clear_checker #(.CNT_W(CNT_W)) u_chk (.clk, .rst, .hsel, .haddr, .htrans,
    .hwrite, .hwdata, .hready, .hrdata, .matchA, .matchB, .matchC, .matchD, .channelCounter);

// [dv/tb_tpu_clk_clear.sv]
`timescale 1ns/100ps

module tb_tpu_clk_clear;
    // ------------------------------------------------------------
    // Stimulus and observation signals
    // ------------------------------------------------------------
    logic             clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, matchC = 1'b0, matchD = 1'b0;
    logic             hready, hresp;
    logic [31:0]      haddr = 32'h0, hwdata = 32'h0, hrdata, rdat;
    logic [1:0]       htrans = 2'h0, phaseTick = 2'h0;
    logic [2:0]       hsize = 3'h2, matchA = 3'h0, matchB = 3'h0;
    logic [3:0]       extClkPin = 4'h0;
    logic [2:0][15:0] channelCounter;
    int               errorCnt = 0, totalChecks = 0, cycles = 0;

    tpu_clk_clear dut (.clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata,
        .hreadyout(hready), .hresp, .extClkPin, .matchA, .matchB, .matchC, .matchD, .phaseTick, .channelCounter);

    // Clock and hang guard
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            errorCnt++;
            printVerdict();
        end
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    // One single bus transfer, address phase then data phase
    task automatic xfer(input int a, input logic w, input logic [31:0] d);
        @(posedge clk);
        hsel   <= 1'b1;
        haddr  <= 32'(a);
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        rdat = hrdata;
    endtask

    // Compare and count
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        totalChecks++;
        if (g !== e) begin
            errorCnt++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask

    // One-cycle match pulse on source s of channel ch
    task automatic pulse(input int ch, input int s);
        @(posedge clk);
        matchA <= 3'(s == 0) << ch;
        matchB <= 3'(s == 1) << ch;
        matchC <= s == 2;
        matchD <= s == 3;
        @(posedge clk);
        {matchA, matchB, matchC, matchD} <= 8'h0;
        #1;
    endtask

    // Counts over 1024 cycles with pin toggles or phase ticks
    task automatic meas(input int ch, input logic [7:0] c, input int pin, input int ph, input int e);
        xfer(4 * ch, 1'b1, 32'(c));
        xfer(12 + 4 * ch, 1'b1, 32'h0);
        for (int i = 0; i < 1024; i++) begin
            @(posedge clk);
            extClkPin <= (pin < 4 && i % 64 < 32) ? 4'(1 << pin) : 4'h0;
            phaseTick <= (ph != 0 && i % 8 == 0) ? 2'(ph) : 2'h0;
        end
        #1;
        chk(32'(channelCounter[ch]), 32'(e));
    endtask

    // Summary and verdict
    task automatic printVerdict();
        $display("checks %0d errors %0d", totalChecks, errorCnt);
        if (errorCnt == 0 && totalChecks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        int e, x;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        for (int a = 0; a < 36; a += 4) begin
            if (a < 12 || a > 20) begin
                xfer(a, 1'b0, 32'h0);
                chk(rdat, 32'h0);
            end
        end
        for (int ch = 0; ch < 3; ch++) begin
            xfer(4 * ch, 1'b1, 32'hff);
            xfer(4 * ch, 1'b0, 32'h0);
            chk(rdat, (ch == 0) ? 32'hff : 32'h7f);
            chk(32'(hresp), 32'h0);
        end
        for (int m = 0; m < 4; m += 3) begin
            xfer(28, 1'b1, 32'(m));
            for (int ch = 0; ch < 3; ch++) begin
                for (int c = 0; c < 8; c++) begin
                    for (int s = 0; s < 4; s++) begin
                        e = (ch == 0) ? c : c & 3;
                        xfer(4 * ch, 1'b1, 32'(c << 5));
                        pulse(ch, s);
                        x = (e == 1 && s == 0) || (e == 2 && s == 1) ||
                            (ch == 0 && m == 0 && (e == 5 && s == 2 || e == 6 && s == 3));
                        chk(32'(channelCounter[ch] == 16'h0), 32'(x));
                    end
                end
            end
        end
        xfer(28, 1'b1, 32'h0);
        xfer(0, 1'b1, 32'he0);
        xfer(4, 1'b1, 32'h20);
        xfer(8, 1'b1, 32'h60);
        xfer(24, 1'b1, 32'h3);
        pulse(1, 0);
        chk(32'(channelCounter[0]), 32'h0);
        chk(32'(channelCounter[2] == 16'h0), 32'h0);
        xfer(0, 1'b1, 32'h60);
        pulse(1, 0);
        chk(32'(channelCounter[0]), 32'h0);
        xfer(24, 1'b1, 32'h0);
        for (int ch = 0; ch < 3; ch++) begin
            for (int p = 0; p < 8; p++) begin
                if (p < 4) meas(ch, 8'(p), 4, 0, 1024 >> (2 * p));
                else if (ch == 0 || p < 6 || (ch == 2 && p == 6)) meas(ch, 8'(p), p - 4, 0, 16);
            end
        end
        meas(1, 8'h06, 4, 0, 4);
        meas(2, 8'h07, 4, 0, 1);
        meas(0, 8'h09, 4, 0, 256);
        meas(0, 8'h0a, 4, 0, 64);
        meas(0, 8'h12, 4, 0, 128);
        meas(0, 8'h14, 0, 0, 32);
        xfer(28, 1'b1, 32'h4);
        meas(1, 8'h00, 4, 1, 128);
        xfer(28, 1'b1, 32'h8);
        meas(2, 8'h00, 4, 2, 128);
        xfer(28, 1'b1, 32'h0);
        xfer(8, 1'b1, 32'h0);
        xfer(20, 1'b1, 32'hff00);
        xfer(4, 1'b1, 32'h07);
        xfer(16, 1'b1, 32'h0);
        repeat (300) @(posedge clk);
        #1;
        chk(32'(channelCounter[1]), 32'h1);
        // Overflow chaining switched off: channel 2 wraps, channel 1 stays
        xfer(28, 1'b1, 32'h10);
        xfer(20, 1'b1, 32'hff00);
        xfer(16, 1'b1, 32'h0);
        repeat (300) @(posedge clk);
        #1;
        chk(32'(channelCounter[1]), 32'h0);
        printVerdict();
    end
endmodule  // tb_tpu_clk_clear
